// ---- rtl/arc_pkg.sv ----
// Purpose: Shared constants for the converter reset, enable and calibration controller.
// Assumes: One 50 MHz clock; converter clock arrives as a synchronous input that is sampled.
// Notes: Register offsets are byte addresses on the plain register port.
// Contract
// - Converter reset low clears all logic, calibration and comparator latches; irq status, mask and conversion length clear only on sys_rst.
// - Converter stays in lowest power state while its reset is low.
// - After reset release converter is uncalibrated and must be recalibrated.
// - Enable gates the converter's internal clocks off when low.
// - Enable low keeps the stored calibration state.
// - A rising calibration start begins a calibration cycle.
// - Calibration ready goes high when calibration completes.
// - Calibration takes about 5500 converter clock cycles.
// - First conversion start right after calibration ready is accepted.
// - Control, status and comparator latches run on the fabric clock.
package arc_pkg;
    localparam int ARC_DATA_W = 12;
    localparam int ARC_CNT_W = 16;
    localparam int ARC_ADDR_W = 8;
    localparam int ARC_NUM_COMP = 3;
    localparam int ARC_CLK_MHZ = 50;
    localparam int ARC_START_FAB_CYCLES = 12;
    localparam int ARC_START_CONV_CYCLES = 8;
    localparam int ARC_CAL_CONV_CYCLES = 5500;
    localparam logic [ARC_CNT_W-1:0] ARC_CONV_LEN_RST = 16'h000E;
    localparam logic [ARC_ADDR_W-1:0] ARC_OFF_STATUS = 8'h00;
    localparam logic [ARC_ADDR_W-1:0] ARC_OFF_IRQ_STAT = 8'h04;
    localparam logic [ARC_ADDR_W-1:0] ARC_OFF_IRQ_MASK = 8'h08;
    localparam logic [ARC_ADDR_W-1:0] ARC_OFF_CONV_LEN = 8'h0C;
    localparam int ARC_IRQ_W = 3;
    localparam int ARC_IRQ_CAL_DONE = 0;
    localparam int ARC_IRQ_CONV_DONE = 1;
    localparam int ARC_IRQ_EARLY_CAL = 2;
    localparam int ARC_ST_CAL_READY = 0;
    localparam int ARC_ST_CALIBRATING = 1;
    localparam int ARC_ST_CONVERTING = 2;
    localparam int ARC_ST_LOW_POWER = 3;
    localparam int ARC_ST_START_OK = 4;
    typedef enum logic [2:0] {
        ARC_OFF,
        ARC_UNCAL,
        ARC_CAL,
        ARC_READY,
        ARC_CONV
    } arc_state_type;
endpackage

// ---- rtl/arc_edge_counter.sv ----
// Purpose: Saturating event counter with a programmable limit.
// Assumes: Step is a one-cycle qualifier; clear has priority over step.
// Notes: Reached stays high while the count equals or passes the limit.
`timescale 1ns/100ps
module arc_edge_counter import arc_pkg::*; #(
    parameter int CNT_W = ARC_CNT_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic step,
    input wire logic [CNT_W-1:0] limit,
    output logic [CNT_W-1:0] count_q,
    output logic reached
);
    initial begin
        if (CNT_W < 4) begin
            $error("arc_edge_counter: CNT_W too small");
        end
    end

    assign reached = (count_q >= limit);

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            count_q <= '0;
        end else if (step && !reached) begin
            count_q <= count_q + 1'b1;
        end
    end
endmodule

// ---- rtl/arc_ctrl.sv ----
// Purpose: Converter reset, enable and calibration sequencing with result and comparator latching.
// Assumes: All inputs are synchronous to clk; conv_clk is sampled and its rising edges counted.
// Notes: Early calibration requests are flagged and ignored rather than started.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module arc_ctrl import arc_pkg::*; #(
    parameter int CAL_CYCLES = ARC_CAL_CONV_CYCLES,
    parameter int DATA_W = ARC_DATA_W,
    parameter int NUM_COMP = ARC_NUM_COMP
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic conv_clk,
    input wire logic conv_rst_n,
    input wire logic conv_en,
    input wire logic cal_start,
    input wire logic conv_soc,
    input wire logic conv_stop,
    input wire logic [DATA_W-1:0] first_sample,
    input wire logic [DATA_W-1:0] second_sample,
    input wire logic [NUM_COMP-1:0] comp_in,
    input wire logic [ARC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic cal_ready,
    output logic conv_busy,
    output logic conv_eoc,
    output logic low_power,
    output logic [DATA_W-1:0] first_converter_result,
    output logic [DATA_W-1:0] second_converter_result,
    output logic [NUM_COMP-1:0] comp_latched,
    output logic irq
);
    initial begin
        if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << ARC_CNT_W)) begin
            $error("arc_ctrl: CAL_CYCLES out of range");
        end
        if (DATA_W < 1 || NUM_COMP < 1) begin
            $error("arc_ctrl: bad width");
        end
    end

    arc_state_type state_q;
    logic conv_clk_q;
    logic cal_start_q;
    logic conv_tick;
    logic cal_rise;
    logic powered;
    logic start_ok;
    logic fab_ok;
    logic conv_ok;
    logic cal_done;
    logic conv_done;
    logic idle_ok;
    logic [ARC_CNT_W-1:0] fab_count;
    logic [ARC_CNT_W-1:0] start_count;
    logic [ARC_CNT_W-1:0] cal_count;
    logic [ARC_CNT_W-1:0] conv_count;
    logic [ARC_CNT_W-1:0] conv_len_q;
    logic [ARC_IRQ_W-1:0] irq_stat_q;
    logic [ARC_IRQ_W-1:0] irq_mask_q;
    logic [ARC_IRQ_W-1:0] irq_event;
    logic [31:0] status_word;

    // Converter clock edges only count while the core is out of reset and its clocks run.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_clk_q <= 1'b0;
            cal_start_q <= 1'b0;
        end else begin
            conv_clk_q <= conv_clk;
            cal_start_q <= cal_start;
        end
    end

    assign powered = conv_rst_n && conv_en;
    assign conv_tick = conv_clk && !conv_clk_q && powered;
    assign cal_rise = cal_start && !cal_start_q;

    // Both start-up spans run at once; the later one decides, as the longer span must.
    arc_edge_counter #(
        .CNT_W(ARC_CNT_W)
    ) u_fab_wait (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(!powered),
        .step(1'b1),
        .limit(ARC_CNT_W'(ARC_START_FAB_CYCLES)),
        .count_q(fab_count),
        .reached(fab_ok)
    );

    arc_edge_counter #(
        .CNT_W(ARC_CNT_W)
    ) u_conv_wait (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(!powered),
        .step(conv_tick),
        .limit(ARC_CNT_W'(ARC_START_CONV_CYCLES)),
        .count_q(start_count),
        .reached(conv_ok)
    );

    assign start_ok = fab_ok && conv_ok && powered;

    arc_edge_counter #(
        .CNT_W(ARC_CNT_W)
    ) u_cal_len (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(state_q != ARC_CAL),
        .step(conv_tick),
        .limit(ARC_CNT_W'(CAL_CYCLES)),
        .count_q(cal_count),
        .reached(cal_done)
    );

    arc_edge_counter #(
        .CNT_W(ARC_CNT_W)
    ) u_conv_len (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(state_q != ARC_CONV),
        .step(conv_tick),
        .limit(conv_len_q),
        .count_q(conv_count),
        .reached(conv_done)
    );

    assign idle_ok = (state_q == ARC_UNCAL) || (state_q == ARC_READY);

    // Converter reset wipes the calibration at once; enable low leaves the state alone.
    always_ff @(posedge clk) begin
        if (sys_rst || !conv_rst_n) begin
            state_q <= ARC_OFF;
        end else begin
            unique case (state_q)
                ARC_OFF: begin
                    state_q <= ARC_UNCAL;
                end
                ARC_UNCAL: begin
                    if (cal_rise && start_ok) begin
                        state_q <= ARC_CAL;
                    end
                end
                ARC_CAL: begin
                    if (cal_done) begin
                        state_q <= ARC_READY;
                    end
                end
                ARC_READY: begin
                    if (conv_soc && conv_en) begin
                        state_q <= ARC_CONV;
                    end else if (cal_rise && start_ok) begin
                        state_q <= ARC_CAL;
                    end
                end
                ARC_CONV: begin
                    if (conv_stop || conv_done) begin
                        state_q <= ARC_READY;
                    end
                end
            endcase
        end
    end

    assign cal_ready = (state_q == ARC_READY) || (state_q == ARC_CONV);
    assign conv_busy = (state_q == ARC_CONV);
    assign low_power = (state_q == ARC_OFF);

    // A stopped conversion ends without a result or an end-of-conversion pulse.
    always_ff @(posedge clk) begin
        if (sys_rst || !conv_rst_n) begin
            conv_eoc <= 1'b0;
            first_converter_result <= '0;
            second_converter_result <= '0;
        end else begin
            conv_eoc <= (state_q == ARC_CONV) && conv_done && !conv_stop;
            if ((state_q == ARC_CONV) && conv_done && !conv_stop) begin
                first_converter_result <= first_sample;
                second_converter_result <= second_sample;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !conv_rst_n) begin
            comp_latched <= '0;
        end else begin
            comp_latched <= comp_in;
        end
    end

    assign irq_event[ARC_IRQ_CAL_DONE] = (state_q == ARC_CAL) && cal_done && conv_rst_n;
    assign irq_event[ARC_IRQ_CONV_DONE] = (state_q == ARC_CONV) && conv_done && !conv_stop
        && conv_rst_n;
    assign irq_event[ARC_IRQ_EARLY_CAL] = cal_rise && !start_ok && idle_ok && conv_rst_n;

    // A new event in the clearing cycle survives the write of one.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_q <= '0;
        end else if (reg_wr && reg_addr == ARC_OFF_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata[ARC_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat_q <= irq_stat_q | irq_event;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_mask_q <= '0;
            conv_len_q <= ARC_CONV_LEN_RST;
        end else if (reg_wr) begin
            if (reg_addr == ARC_OFF_IRQ_MASK) begin
                irq_mask_q <= reg_wdata[ARC_IRQ_W-1:0];
            end
            if (reg_addr == ARC_OFF_CONV_LEN) begin
                conv_len_q <= reg_wdata[ARC_CNT_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    always_comb begin
        status_word = '0;
        status_word[ARC_ST_CAL_READY] = cal_ready;
        status_word[ARC_ST_CALIBRATING] = (state_q == ARC_CAL);
        status_word[ARC_ST_CONVERTING] = conv_busy;
        status_word[ARC_ST_LOW_POWER] = low_power;
        status_word[ARC_ST_START_OK] = start_ok;
    end

    // Read data stand one cycle after each cycle of read strobe and clear when it drops; unmapped offsets read as zero.
    always_ff @(posedge clk) begin
        if (sys_rst || !reg_rd) begin
            reg_rdata <= '0;
        end else begin
            unique case (reg_addr)
                ARC_OFF_STATUS: reg_rdata <= status_word;
                ARC_OFF_IRQ_STAT: reg_rdata <= {{(32-ARC_IRQ_W){1'b0}}, irq_stat_q};
                ARC_OFF_IRQ_MASK: reg_rdata <= {{(32-ARC_IRQ_W){1'b0}}, irq_mask_q};
                ARC_OFF_CONV_LEN: reg_rdata <= {{(32-ARC_CNT_W){1'b0}}, conv_len_q};
                default: reg_rdata <= '0;
            endcase
        end
    end

    AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
        !conv_rst_n |=> low_power && !cal_ready && !conv_eoc && comp_latched == '0)
        else $error("converter reset did not clear state");

    AST_LOW_POWER_HELD: assert property (@(posedge clk) disable iff (sys_rst)
        !conv_rst_n [*2] |-> low_power)
        else $error("not in low power while reset held");

    AST_UNCAL_AFTER_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(conv_rst_n) |-> !cal_ready ##1 !cal_ready)
        else $error("calibrated right after reset release");

    AST_GATED_TICK: assert property (@(posedge clk) disable iff (sys_rst)
        !conv_en |-> !conv_tick)
        else $error("converter clock ran while disabled");
    // Calibration and conversion counters freeze while the enable is low, so paused work resumes where it stopped; the start-up wait restarts.
    AST_CAL_PAUSED: assert property (@(posedge clk) disable iff (sys_rst)
        !conv_en && state_q == ARC_CAL |=> $stable(cal_count))
        else $error("calibration count moved while disabled");
    AST_CONV_PAUSED: assert property (@(posedge clk) disable iff (sys_rst)
        !conv_en && state_q == ARC_CONV |=> $stable(conv_count))
        else $error("conversion count moved while disabled");
    AST_WAIT_RESTARTS: assert property (@(posedge clk) disable iff (sys_rst)
        !powered |=> fab_count == '0 && start_count == '0)
        else $error("start-up wait not restarted");

    AST_EN_KEEPS_CAL: assert property (@(posedge clk) disable iff (sys_rst)
        cal_ready && conv_rst_n && !conv_en |=> cal_ready)
        else $error("enable low lost calibration");

    AST_EARLY_CAL_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
        cal_rise && idle_ok && conv_rst_n && !start_ok |=> irq_stat_q[ARC_IRQ_EARLY_CAL]
        && state_q != ARC_CAL)
        else $error("early calibration start not refused");

    AST_CAL_BEGINS: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ARC_UNCAL && cal_rise && start_ok |=> state_q == ARC_CAL)
        else $error("calibration did not begin");

    AST_CAL_READY_RISES: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ARC_CAL && cal_done && conv_rst_n |=> cal_ready
        && irq_stat_q[ARC_IRQ_CAL_DONE])
        else $error("calibration ready missing");

    AST_CAL_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(cal_ready) && $past(state_q) == ARC_CAL |-> $past(cal_count) == CAL_CYCLES)
        else $error("calibration length wrong");

    AST_READY_LOW_IN_CAL: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ARC_CAL && !cal_done |=> !cal_ready)
        else $error("ready high during calibration");

    AST_SOC_ACCEPTED: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ARC_READY && conv_soc && conv_en && conv_rst_n |=> conv_busy)
        else $error("conversion start refused");

    AST_COMP_SYNC: assert property (@(posedge clk) disable iff (sys_rst)
        conv_rst_n |=> comp_latched == $past(comp_in))
        else $error("comparator latch wrong");

    // Calibration only begins from a counted request; ready only falls by reset or recalibration.
    AST_NO_EARLY_CAL: assert property (@(posedge clk) disable iff (sys_rst)
        !start_ok && state_q != ARC_CAL |=> state_q != ARC_CAL)
        else $error("calibration began before the start-up wait");
    AST_CAL_NEEDS_REQUEST: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(state_q == ARC_CAL) |-> $past(cal_rise) && $past(start_ok))
        else $error("calibration began without a request");
    AST_READY_STAYS: assert property (@(posedge clk) disable iff (sys_rst)
        cal_ready && conv_rst_n && !cal_rise |=> cal_ready)
        else $error("calibration ready dropped");
    AST_READY_LOW_AFTER_RST: assert property (@(posedge clk) disable iff (sys_rst)
        !conv_rst_n |=> !cal_ready ##1 !cal_ready)
        else $error("ready high right after converter reset");
    AST_UNCAL_NEXT: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ARC_OFF && conv_rst_n |=> state_q == ARC_UNCAL)
        else $error("did not leave reset uncalibrated");
    AST_CONV_FROM_READY: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(conv_busy) |-> $past(cal_ready) && $past(conv_soc) && $past(conv_en))
        else $error("conversion began without a taken start");
    AST_EOC_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        conv_eoc |=> !conv_eoc)
        else $error("end of conversion longer than one cycle");
    AST_RESULT_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst)
        conv_eoc |-> first_converter_result == $past(first_sample)
        && second_converter_result == $past(second_sample))
        else $error("results not captured with end of conversion");
    AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        conv_rst_n && !(state_q == ARC_CONV && conv_done && !conv_stop)
        |=> $stable(first_converter_result) && $stable(second_converter_result))
        else $error("results changed without a finished conversion");
endmodule

// ---- tb/arc_fabric_model.sv ----
// Purpose: Fabric-side controller that sequences converter reset, enable and calibration start.
// Assumes: One clock; the converter clock is made here as one rising edge every four clk cycles.
// Notes: Hasty raises calibration start before the settling wait, to provoke a refusal.
`timescale 1ns/100ps
module arc_fabric_model import arc_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic sleep,
    input wire logic hasty,
    output logic conv_clk,
    output logic conv_rst_n,
    output logic conv_en,
    output logic cal_start
);
    logic [1:0] div_q;
    logic [4:0] fab_q;
    logic [4:0] edge_q;
    logic met;

    // A small margin above the minimum keeps the request clear of counting skew in the device.
    assign met = (fab_q >= 5'(ARC_START_FAB_CYCLES + 2))
        && (edge_q >= 5'(ARC_START_CONV_CYCLES + 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= 2'h0;
            conv_clk <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            conv_clk <= div_q[1];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_rst_n <= 1'b0;
            conv_en <= 1'b0;
        end else begin
            conv_rst_n <= run;
            conv_en <= run & ~sleep;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !conv_rst_n) begin
            fab_q <= 5'h00;
            edge_q <= 5'h00;
        end else if (conv_en) begin
            if (fab_q != 5'h1F) begin
                fab_q <= fab_q + 5'h01;
            end
            if (div_q == 2'h1 && edge_q != 5'h1F) begin
                edge_q <= edge_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cal_start <= 1'b0;
        end else begin
            cal_start <= conv_rst_n & (hasty | met);
        end
    end
endmodule

// ---- tb/adc_reset_enable_calibration_ctrl_bench.sv ----
// Purpose: Self-checking bench for the converter reset, enable and calibration controller.
// Assumes: Calibration shortened to CAL converter cycles; conversions set to four cycles.
// Notes: The sample inputs are held constant; the stop input is pulsed once.
`timescale 1ns/100ps
module adc_reset_enable_calibration_ctrl_bench import arc_pkg::*; ();
    localparam int CAL = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic run = 1'b0;
    logic sleep = 1'b0;
    logic hasty = 1'b0;
    logic conv_soc = 1'b0;
    logic conv_stop = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ARC_ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [ARC_DATA_W-1:0] first_sample = 12'hA5C;
    logic [ARC_DATA_W-1:0] second_sample = 12'h3F1;
    logic [ARC_NUM_COMP-1:0] comp_in = 3'h2;
    logic conv_clk, conv_rst_n, conv_en, cal_start;
    logic cal_ready, conv_busy, conv_eoc, low_power, irq;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    logic [ARC_DATA_W-1:0] first_converter_result, second_converter_result;
    logic [ARC_NUM_COMP-1:0] comp_latched;
    int bad_count = 0;
    int compares = 0;
    int n, t;

    always #10 clk = ~clk;

    arc_fabric_model u_arc_fabric_model (.clk, .sys_rst, .run, .sleep, .hasty, .conv_clk,
        .conv_rst_n, .conv_en, .cal_start);

    arc_ctrl #(.CAL_CYCLES(CAL)) u_arc_ctrl (.clk, .sys_rst, .conv_clk, .conv_rst_n, .conv_en,
        .cal_start, .conv_soc, .conv_stop, .first_sample, .second_sample, .comp_in, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cal_ready, .conv_busy, .conv_eoc, .low_power,
        .first_converter_result, .second_converter_result, .comp_latched, .irq);

    task automatic tally_and_finish();
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Start of conversion is one cycle long; effects are sampled just after the taking edge.
    task automatic soc_pulse();
        @(posedge clk);
        conv_soc <= 1'b1;
        @(posedge clk);
        conv_soc <= 1'b0;
        #1;
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return cal_start === 1'b1;
            1: return cal_ready === 1'b1;
            default: return conv_eoc === 1'b1;
        endcase
    endfunction

    task automatic wait_on(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (!sig(sel) && cnt < lim) begin
            @(posedge clk);
            #1 cnt++;
        end
        if (cnt >= lim) begin
            bad_count++;
            $display("[FAIL] %0t wait ran out", $time);
            tally_and_finish();
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        reg_read(ARC_OFF_STATUS, rd);
        check(rd & 32'h9, 32'h8, "status after reset");
        reg_write(ARC_OFF_CONV_LEN, 32'h4);
        reg_write(ARC_OFF_IRQ_MASK, 32'h7);
        run <= 1'b1;
        hasty <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check(low_power, 1'b0, "low power after release");
        reg_read(ARC_OFF_IRQ_STAT, rd);
        check(rd, 32'h4, "early start flagged");
        check(irq, 1'b1, "irq for early start");
        reg_read(ARC_OFF_STATUS, rd);
        check(rd & 32'h13, 32'h0, "early start not begun");
        reg_write(ARC_OFF_IRQ_STAT, 32'h4);
        reg_read(ARC_OFF_IRQ_STAT, rd);
        check({rd[30:0], irq}, 32'h0, "flag cleared");
        @(posedge clk);
        run <= 1'b0;
        hasty <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(low_power, 1'b1, "low power in reset");
        @(posedge clk);
        run <= 1'b1;
        wait_on(0, 200, n);
        repeat (10) @(posedge clk);
        reg_read(ARC_OFF_STATUS, rd);
        check(rd & 32'hB, 32'h2, "calibrating");
        wait_on(1, 400, t);
        check((t + 11 >= CAL * 4 - 6) && (t + 11 <= CAL * 4 + 6), 1'b1, "cal length");
        soc_pulse();
        check(conv_busy, 1'b1, "first conversion taken");
        wait_on(2, 100, n);
        check({first_converter_result, second_converter_result}, {first_sample, second_sample},
            "results");
        reg_read(ARC_OFF_IRQ_STAT, rd);
        check(rd, 32'h3, "cal and conversion done");
        reg_write(ARC_OFF_IRQ_STAT, 32'h3);
        @(posedge clk);
        comp_in <= 3'h5;
        @(posedge clk);
        #1 check(comp_latched, 3'h5, "comparator latch");
        @(posedge clk);
        sleep <= 1'b1;
        repeat (30) @(posedge clk);
        soc_pulse();
        check(conv_busy, 1'b0, "no conversion while gated");
        check(cal_ready, 1'b1, "calibration kept while gated");
        @(posedge clk);
        sleep <= 1'b0;
        repeat (3) @(posedge clk);
        soc_pulse();
        check(conv_busy, 1'b1, "conversion after wake");
        wait_on(2, 100, n);
        reg_write(ARC_OFF_IRQ_STAT, 32'h2);
        soc_pulse();
        check(conv_busy, 1'b1, "conversion to be stopped");
        @(posedge clk);
        conv_stop <= 1'b1;
        @(posedge clk);
        conv_stop <= 1'b0;
        #1 check(conv_busy, 1'b0, "stop ends conversion");
        repeat (20) @(posedge clk);
        reg_read(ARC_OFF_IRQ_STAT, rd);
        check(rd & 32'h2, 32'h0, "stopped conversion not done");
        @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check({cal_ready, low_power, comp_latched}, {1'b0, 1'b1, 3'h0},
            "reset clear");
        check({first_converter_result, second_converter_result}, 32'h0,
            "results clear");
        @(posedge clk);
        run <= 1'b1;
        wait_on(0, 200, n);
        check(cal_ready, 1'b0, "uncalibrated after release");
        repeat (2) @(posedge clk);
        sleep <= 1'b1;
        repeat (12) @(posedge clk);
        sleep <= 1'b0;
        reg_read(ARC_OFF_STATUS, rd);
        check(rd & 32'h3, 32'h2, "calibration paused, not lost");
        wait_on(1, 400, n);
        reg_read(ARC_OFF_IRQ_STAT, rd);
        check(rd & 32'h1, 32'h1, "recalibrated");
        tally_and_finish();
    end
endmodule
